// >>> hdl/ir_key_consts.svh
/*
  Constants for the remote-key command interpreter: key codes, timing
  figures and reset values. Assumes a 25 MHz core clock.
*/
// What this block does
// - Valid key answered by one flash
// - Invalid key: five quick flashes, command discarded
// - Test key enters test mode, one flash
// - 15 s idle leaves test mode, one flash
// - Read plus config key flashes its value
// - Pattern read flashes its remote number
// - Zero digit is one 2 s flash
// - Digits sent hundreds, tens, ones with pauses
// - Pattern number always three digits
// - Intensity read flashes level one to four
// - Pattern key plus three digits loads pattern
// - Intensity digits 1..4 select 25..100 percent
// - Battery read flashes 4..1 by voltage band
// - Lux key plus level 1..5 sets thresholds
// - Lux level defaults to 2
// - Out-of-range value rejected with five flashes
// - Completed sequence acknowledged by 1 s flash
// - Settings follow last change, remote or switch
`ifndef IR_KEY_CONSTS_SVH
`define IR_KEY_CONSTS_SVH
// Key codes from the decoder; digits are 0..9
`define KEY_TEST 5'h10
`define KEY_READ 5'h11
`define KEY_LUX 5'h12
`define KEY_PATTERN 5'h13
`define KEY_INTENSITY 5'h14
`define KEY_BATTERY 5'h15
// Times in milliseconds, cycle counts derived at 25 MHz
`define CLK_KHZ 25000
`define T_SHORT_ON_MS 300
`define T_SHORT_OFF_MS 300
`define T_QUICK_MS 100
`define T_ZERO_MS 2000
`define T_ACK_MS 1000
`define T_GAP_MS 1500
`define T_IDLE_MS 15000
`define CYC(ms) ((ms) * `CLK_KHZ)
// Reset values and error flash count
`define LUX_RESET 3'h2
`define INT_RESET 2'h3
`define ERR_FLASHES 4'h5
`endif

// >>> hdl/ir_key_pkg.sv
/*
  Types shared by the interpreter and its lamp sequencer.
  Assumes the constants header is included beside it.
*/
package ir_key_pkg;
  // One queued flash response
  typedef struct packed {
    logic [3:0] count; // flashes of one kind
    logic [1:0] kind; // 0 short, 1 quick, 2 long ack, 3 zero
  } flash_req_t;
  typedef enum logic [1:0] {K_SHORT, K_QUICK, K_ACK, K_ZERO} flash_kind_t;
  // Configuration handed to the lamp driver
  typedef struct packed {
    logic [7:0] pattern; // remote pattern number
    logic [1:0] intensity; // 0..3 = 25..100 percent
    logic [2:0] lux_level; // 1..5
  } lamp_cfg_t;
endpackage

// >>> hdl/flash_seq.sv
/*
  Lamp flash sequencer: plays a group of equal flashes then a gap.
  Assumes one request is offered only while idle.
*/
`timescale 1ns/100ps
`include "ir_key_consts.svh"
module flash_seq #(
  parameter int SCALE = 1 // Divides every time, for fast simulation
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire ir_key_pkg::flash_req_t req,
  input wire logic gap_after, // Insert digit pause at end
  output logic busy,
  output logic lamp_on
);
  logic [31:0] tmr_r; // Phase timer
  logic [3:0] left_r; // Flashes still to play
  logic [1:0] kind_r;
  logic on_r;
  logic gap_r;
  // On time per kind
  function automatic logic [31:0] on_len(input logic [1:0] k);
    case (k)
      2'h1: on_len = 32'(`CYC(`T_QUICK_MS) / SCALE);
      2'h2: on_len = 32'(`CYC(`T_ACK_MS) / SCALE);
      2'h3: on_len = 32'(`CYC(`T_ZERO_MS) / SCALE);
      default: on_len = 32'(`CYC(`T_SHORT_ON_MS) / SCALE);
    endcase
  endfunction
  // Flash and pause sequencing
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tmr_r <= 32'h0;
      left_r <= 4'h0;
      kind_r <= 2'h0;
      on_r <= 1'b0;
      gap_r <= 1'b0;
    end else if (start && !busy) begin
      left_r <= req.count;
      kind_r <= req.kind;
      gap_r <= gap_after;
      on_r <= 1'b1;
      tmr_r <= on_len(req.kind);
    end else if (tmr_r > 32'h1) begin
      tmr_r <= tmr_r - 32'h1;
    end else if (tmr_r == 32'h1) begin
      if (on_r) begin
        // Off phase; last flash takes the digit pause if asked
        on_r <= 1'b0;
        left_r <= left_r - 4'h1;
        if (left_r == 4'h1) begin
          tmr_r <= gap_r ? 32'(`CYC(`T_GAP_MS) / SCALE) : 32'h0;
        end else begin
          tmr_r <= 32'(`CYC(kind_r == 2'h1 ? `T_QUICK_MS : `T_SHORT_OFF_MS) / SCALE);
        end
      end else if (left_r != 4'h0) begin
        on_r <= 1'b1;
        tmr_r <= on_len(kind_r);
      end else begin
        tmr_r <= 32'h0;
      end
    end
  end
  assign busy = (tmr_r != 32'h0);
  assign lamp_on = on_r;
endmodule

// >>> hdl/ir_key_interp.sv
/*
  Remote-key command interpreter: decodes key sequences, keeps lamp
  configuration and queues flash responses to the sequencer.
  Assumes keys arrive as one-cycle strobes from an infrared decoder.
*/
`timescale 1ns/100ps
`include "ir_key_consts.svh"
module ir_key_interp #(
  parameter int SCALE = 1 // Shortens all times in simulation
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic key_valid, // One-cycle key strobe
  input wire logic [4:0] key_code,
  input wire logic test_hold, // Test key held up to 5 s, decoded upstream
  input wire logic [7:0] switch_pattern, // Pattern number from board switches
  input wire logic [1:0] switch_intensity,
  input wire logic [1:0] battery_band, // 0 flat .. 3 high
  output logic lamp_on,
  output logic test_mode,
  output logic busy,
  output ir_key_pkg::lamp_cfg_t cfg
);
  typedef enum {S_IDLE, S_READ, S_PAT_D, S_INT_D, S_LUX_D} state_t;
  state_t state_r;
  logic [1:0] digs_r; // Pattern digits taken
  logic [9:0] acc_r; // Accumulated pattern number
  logic [31:0] idle_r; // Test-mode idle timer
  logic [7:0] sw_pat_r; // Last seen switch pattern
  logic [1:0] sw_int_r;
  logic sw_seen_r; // Switch sample taken after reset
  // Response queue: up to three digits
  ir_key_pkg::flash_req_t q_r [3];
  logic [1:0] qn_r; // Entries pending
  logic seq_busy;
  logic seq_start;
  logic is_digit;
  logic [3:0] dig;
  logic accept;
  ir_key_pkg::lamp_cfg_t cfg_r;
  localparam logic [31:0] IDLE_CYC = 32'(`CYC(`T_IDLE_MS) / SCALE);
  assign is_digit = (key_code <= 5'h09);
  assign dig = key_code[3:0];
  assign busy = seq_busy || (qn_r != 2'h0);
  assign accept = key_valid && !busy;
  assign seq_start = !seq_busy && (qn_r != 2'h0);
  assign cfg = cfg_r;
  // Digit flash request, zero becomes one long flash
  function automatic ir_key_pkg::flash_req_t dreq(input logic [3:0] d);
    dreq.count = (d == 4'h0) ? 4'h1 : d;
    dreq.kind = (d == 4'h0) ? 2'h3 : 2'h0;
  endfunction
  function automatic ir_key_pkg::flash_req_t mreq(input logic [3:0] n, input logic [1:0] k);
    mreq.count = n;
    mreq.kind = k;
  endfunction
  // Key decoding, configuration and response queue
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      digs_r <= 2'h0;
      acc_r <= 10'h0;
      qn_r <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        q_r[i] <= '0;
      end
      cfg_r.pattern <= 8'h0;
      cfg_r.intensity <= `INT_RESET;
      cfg_r.lux_level <= `LUX_RESET;
      sw_pat_r <= 8'h0;
      sw_int_r <= 2'h0;
      sw_seen_r <= 1'b0;
    end else begin
      // Switch changes, also those made while unpowered, take over
      if (!sw_seen_r || switch_pattern != sw_pat_r) begin
        cfg_r.pattern <= switch_pattern;
      end
      if (!sw_seen_r || switch_intensity != sw_int_r) begin
        cfg_r.intensity <= switch_intensity;
      end
      sw_pat_r <= switch_pattern;
      sw_int_r <= switch_intensity;
      sw_seen_r <= 1'b1;
      if (seq_start) begin
        // Pop front entry
        q_r[0] <= q_r[1];
        q_r[1] <= q_r[2];
        qn_r <= qn_r - 2'h1;
      end
      if (accept && test_mode) begin
        // Default answer: one flash for a taken key
        q_r[0] <= mreq(4'h1, 2'h0);
        qn_r <= 2'h1;
        state_r <= S_IDLE;
        case (state_r)
          S_IDLE: begin
            if (key_code == `KEY_READ) state_r <= S_READ;
            else if (key_code == `KEY_PATTERN) begin
              state_r <= S_PAT_D;
              digs_r <= 2'h0;
              acc_r <= 10'h0;
            end else if (key_code == `KEY_INTENSITY) state_r <= S_INT_D;
            else if (key_code == `KEY_LUX) state_r <= S_LUX_D;
            else if (key_code != `KEY_TEST) begin
              q_r[0] <= mreq(`ERR_FLASHES, 2'h1);
            end
          end
          S_READ: begin
            if (key_code == `KEY_PATTERN) begin
              // Always three digits of the remote number
              q_r[0] <= dreq(4'(cfg_r.pattern / 8'd100));
              q_r[1] <= dreq(4'((cfg_r.pattern / 8'd10) % 8'd10));
              q_r[2] <= dreq(4'(cfg_r.pattern % 8'd10));
              qn_r <= 2'h3;
            end else if (key_code == `KEY_INTENSITY) begin
              q_r[0] <= dreq({2'h0, cfg_r.intensity} + 4'h1);
            end else if (key_code == `KEY_BATTERY) begin
              q_r[0] <= dreq({2'h0, battery_band} + 4'h1);
            end else if (key_code == `KEY_LUX) begin
              q_r[0] <= dreq({1'b0, cfg_r.lux_level});
            end else begin
              q_r[0] <= mreq(`ERR_FLASHES, 2'h1);
            end
          end
          S_PAT_D: begin
            if (!is_digit) q_r[0] <= mreq(`ERR_FLASHES, 2'h1);
            else if (digs_r != 2'h2) begin
              acc_r <= 10'(acc_r * 10'd10 + {6'h0, dig});
              digs_r <= digs_r + 2'h1;
              state_r <= S_PAT_D;
            end else if (10'(acc_r * 10'd10 + {6'h0, dig}) > 10'd255) begin
              q_r[0] <= mreq(`ERR_FLASHES, 2'h1);
            end else begin
              cfg_r.pattern <= 8'(acc_r * 10'd10 + {6'h0, dig});
              q_r[0] <= mreq(4'h1, 2'h2);
            end
          end
          S_INT_D: begin
            if (is_digit && dig >= 4'h1 && dig <= 4'h4) begin
              cfg_r.intensity <= 2'(dig - 4'h1);
              q_r[0] <= mreq(4'h1, 2'h2);
            end else q_r[0] <= mreq(`ERR_FLASHES, 2'h1);
          end
          S_LUX_D: begin
            if (is_digit && dig >= 4'h1 && dig <= 4'h5) begin
              cfg_r.lux_level <= 3'(dig);
              q_r[0] <= mreq(4'h1, 2'h2);
            end else q_r[0] <= mreq(`ERR_FLASHES, 2'h1);
          end
          default: state_r <= S_IDLE;
        endcase
      end else if (accept && test_hold) begin
        q_r[0] <= mreq(4'h1, 2'h0);
        qn_r <= 2'h1;
      end else if (test_mode && !busy && idle_r == 32'h1) begin
        q_r[0] <= mreq(4'h1, 2'h0);
        qn_r <= 2'h1;
        state_r <= S_IDLE;
      end
    end
  end
  // Test-mode entry and idle timeout
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      test_mode <= 1'b0;
      idle_r <= 32'h0;
    end else if (!test_mode && accept && test_hold) begin
      test_mode <= 1'b1;
      idle_r <= IDLE_CYC;
    end else if (test_mode && accept) begin
      idle_r <= IDLE_CYC;
    end else if (test_mode && !busy) begin
      // Timer only runs when no answer is being flashed
      if (idle_r <= 32'h1) test_mode <= 1'b0;
      idle_r <= idle_r - 32'h1;
    end
  end
  flash_seq #(.SCALE(SCALE)) u_seq (
    .core_clk(core_clk),
    .resetn(resetn),
    .start(seq_start),
    .req(q_r[0]),
    .gap_after(qn_r != 2'h1),
    .busy(seq_busy),
    .lamp_on(lamp_on)
  );
  // Rule checks sit beside the logic; each names the rule it guards
  AST_LAMP_OFF_IDLE: assert property (@(posedge core_clk) disable iff (!resetn)
    !busy |-> !lamp_on) else $error("lamp lit while idle");
  // A key offered during an answer must not touch the settings
  AST_IGNORE_BUSY: assert property (@(posedge core_clk) disable iff (!resetn)
    busy && key_valid |=> $stable(cfg_r)) else $error("key taken while busy");
  AST_KEY_ANSWER: assert property (@(posedge core_clk) disable iff (!resetn)
    accept && test_mode |=> qn_r != 2'h0) else $error("no answer queued");
  AST_INT_SET: assert property (@(posedge core_clk) disable iff (!resetn)
    accept && test_mode && state_r == S_INT_D && key_code == 5'h02
    |=> cfg_r.intensity == 2'h1) else $error("intensity not set");
  AST_LUX_RANGE: assert property (@(posedge core_clk) disable iff (!resetn)
    cfg_r.lux_level >= 3'h1 && cfg_r.lux_level <= 3'h5) else $error("lux out of range");
  // Out-of-range level: five quick flashes and the command is dropped
  AST_LUX_BAD: assert property (@(posedge core_clk) disable iff (!resetn)
    accept && test_mode && state_r == S_LUX_D && key_code == 5'h06
    |=> q_r[0].count == 4'h5 && state_r == S_IDLE) else $error("bad lux kept");
  AST_ERR_QUICK: assert property (@(posedge core_clk) disable iff (!resetn)
    accept && test_mode && state_r == S_IDLE && key_code == 5'h03
    |=> q_r[0].kind == 2'h1) else $error("invalid key not rejected");
  AST_PAT_THREE: assert property (@(posedge core_clk) disable iff (!resetn)
    accept && test_mode && state_r == S_READ && key_code == `KEY_PATTERN
    |=> qn_r == 2'h3) else $error("pattern read not three digits");
  // Intensity read answers one digit between one and four
  AST_INT_READ: assert property (@(posedge core_clk) disable iff (!resetn)
    accept && test_mode && state_r == S_READ && key_code == `KEY_INTENSITY
    |=> q_r[0].count >= 4'h1 && q_r[0].count <= 4'h4 && q_r[0].kind == 2'h0)
    else $error("intensity read out of range");
  // Idle lapse drops test mode and queues one short flash
  AST_IDLE_EXIT: assert property (@(posedge core_clk) disable iff (!resetn)
    test_mode && !busy && !key_valid && idle_r == 32'h1
    |=> !test_mode && qn_r == 2'h1 && q_r[0].kind == 2'h0)
    else $error("test mode did not lapse");
  // Main scenarios: entry, exit, three-digit read, error and acknowledge
  COV_TEST: cover property (@(posedge core_clk) disable iff (!resetn) $rose(test_mode));
  COV_EXIT: cover property (@(posedge core_clk) disable iff (!resetn) $fell(test_mode));
  COV_READ: cover property (@(posedge core_clk) disable iff (!resetn) qn_r == 2'h3);
  COV_ERR: cover property (@(posedge core_clk) disable iff (!resetn)
    seq_start && q_r[0].kind == 2'h1);
  COV_ACK: cover property (@(posedge core_clk) disable iff (!resetn)
    seq_start && q_r[0].kind == 2'h2);
endmodule

// >>> dv/ir_remote_model.sv
/*
  Behavioural handheld remote: sends one key code at a time as a strobe.
  Assumes the interpreter raises busy the cycle after it takes a key.
*/
`timescale 1ns/100ps
module ir_remote_model #(
  parameter int WAIT_CYC = 3750 // Answer wait, 3 s after scaling
) (
  input wire logic core_clk,
  input wire logic busy,
  output logic key_valid,
  output logic [4:0] key_code,
  output logic test_hold
);
  // Idle remote sends nothing
  initial begin
    key_valid = 1'b0;
    key_code = 5'h1F;
    test_hold = 1'b0;
  end
  // One press; resent once if no answer shows, like a person would
  task automatic press(input logic [4:0] code, input logic hold, input logic wait_ans);
    int tries;
    int cnt;
    for (tries = 0; tries < 2; tries++) begin
      @(posedge core_clk);
      #1;
      key_valid = 1'b1;
      key_code = code;
      test_hold = hold;
      @(posedge core_clk);
      #1;
      key_valid = 1'b0;
      key_code = ~code; // Released code never repeats the last key
      test_hold = 1'b0;
      if (!wait_ans) begin
        tries = 2;
      end
      cnt = 0;
      while (wait_ans && busy !== 1'b1 && cnt < WAIT_CYC) begin
        @(posedge core_clk);
        #1;
        cnt++;
      end
      if (busy === 1'b1 && wait_ans) begin
        while (busy !== 1'b0) begin
          @(posedge core_clk);
          #1;
        end
        tries = 2;
      end
    end
  endtask
endmodule

// >>> dv/ir_key_command_interpreter_test.sv
/*
  Self-checking bench for the key interpreter: the remote model presses keys,
  a monitor sorts each lamp flash by length and compares it with the queue.
  Assumes times shortened by SCALE and the consts header on the include path.
*/
`timescale 1ns/100ps
`include "ir_key_consts.svh"
module ir_key_command_interpreter_test;
  localparam int SCALE = 20000; // 0.3 s short flash becomes 375 cycles
  logic core_clk, resetn, key_valid, test_hold, lamp_on, test_mode, busy;
  logic [4:0] key_code;
  logic [7:0] switch_pattern;
  logic [1:0] switch_intensity, battery_band;
  ir_key_pkg::lamp_cfg_t cfg;
  logic [1:0] exp_q[$]; // Expected flash kinds, oldest first
  logic [1:0] ek, kind;
  int seed = 45709;
  int error_cnt, checks_done, cycles, len, i, val, cnt;

  ir_key_interp #(.SCALE(SCALE)) dut_u (.core_clk(core_clk), .resetn(resetn),
    .key_valid(key_valid), .key_code(key_code), .test_hold(test_hold),
    .switch_pattern(switch_pattern), .switch_intensity(switch_intensity),
    .battery_band(battery_band), .lamp_on(lamp_on), .test_mode(test_mode),
    .busy(busy), .cfg(cfg));
  ir_remote_model #(.WAIT_CYC(3750)) rm_u (.core_clk(core_clk), .busy(busy),
    .key_valid(key_valid), .key_code(key_code), .test_hold(test_hold));

  // Free-running 25 MHz clock
  always #20 core_clk = ~core_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp_v);
    checks_done++;
    if (seen !== exp_v) begin
      error_cnt++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp_v);
    end
  endtask

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Number of short flashes, or one long flash for a zero digit
  task automatic exp_num(input int n);
    if (n == 0) begin
      exp_q.push_back(2'h3);
    end else begin
      repeat (n) exp_q.push_back(2'h0);
    end
  endtask

  task automatic key(input logic [4:0] c, input logic [1:0] answer);
    exp_q.push_back(answer);
    rm_u.press(c, 1'b0, 1'b1);
  endtask

  // Flash sorter: length buckets sit midway between the nominal widths
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 90000) begin
      error_cnt++;
      wrap_up;
    end
    if (lamp_on === 1'b1) begin
      len++;
    end else if (len > 0) begin
      kind = (len < 250) ? 2'h1 : (len < 812) ? 2'h0 : (len < 1875) ? 2'h2 : 2'h3;
      ek = (exp_q.size() > 0) ? exp_q.pop_front() : 2'bxx; // Unexpected flash fails
      check(kind, ek);
      len = 0;
    end
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    // Switch settings at power-up come from the seeded stream
    switch_pattern = 8'($random(seed));
    switch_intensity = 2'($random(seed));
    battery_band = 2'($random(seed));
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check(cfg.lux_level, 3'h2);
    check(cfg.pattern, switch_pattern);
    check(cfg.intensity, switch_intensity);
    exp_q.push_back(2'h0);
    rm_u.press(`KEY_TEST, 1'b1, 1'b1);
    check(test_mode, 1'b1);
    // Every intensity digit, each ending in a long acknowledge
    for (i = 1; i <= 4; i++) begin
      key(`KEY_INTENSITY, 2'h0);
      key(i[4:0], 2'h2);
      check(cfg.intensity, i - 1);
    end
    // Read back level; a key sent mid-answer must leave no trace
    key(`KEY_READ, 2'h0);
    exp_num(4);
    rm_u.press(`KEY_INTENSITY, 1'b0, 1'b0);
    rm_u.press(`KEY_LUX, 1'b0, 1'b1);
    // Out-of-range level, then a stray digit: five quick flashes each
    key(`KEY_INTENSITY, 2'h0);
    repeat (4) exp_q.push_back(2'h1);
    key(5'h05, 2'h1);
    check(cfg.intensity, 2'h3);
    repeat (4) exp_q.push_back(2'h1);
    key(5'h03, 2'h1);
    // Pattern with a zero ones digit, then read it back
    val = ($unsigned($random(seed)) % 26) * 10;
    key(`KEY_PATTERN, 2'h0);
    key(5'(val / 100), 2'h0);
    key(5'((val / 10) % 10), 2'h0);
    key(5'(val % 10), 2'h2);
    check(cfg.pattern, 16'(val));
    exp_q.push_back(2'h0);
    rm_u.press(`KEY_READ, 1'b0, 1'b1);
    exp_num(val / 100);
    exp_num((val / 10) % 10);
    exp_num(val % 10);
    rm_u.press(`KEY_PATTERN, 1'b0, 1'b1);
    // The sorter takes the last flash one edge after busy falls
    repeat (2) @(posedge core_clk);
    #1;
    check(exp_q.size(), 16'h0000);
    // Battery band from the seeded stream
    battery_band = 2'($random(seed));
    exp_q.push_back(2'h0);
    rm_u.press(`KEY_READ, 1'b0, 1'b1);
    exp_num(battery_band + 1);
    rm_u.press(`KEY_BATTERY, 1'b0, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    check(exp_q.size(), 16'h0000);
    // Level six is out of range and leaves the default level alone
    key(`KEY_LUX, 2'h0);
    repeat (4) exp_q.push_back(2'h1);
    key(5'h06, 2'h1);
    check(cfg.lux_level, 3'h2);
    key(`KEY_LUX, 2'h0);
    key(5'h05, 2'h2);
    check(cfg.lux_level, 3'h5);
    // Lux read flashes the level as one digit
    exp_q.push_back(2'h0);
    rm_u.press(`KEY_READ, 1'b0, 1'b1);
    exp_num(5);
    rm_u.press(`KEY_LUX, 1'b0, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    check(exp_q.size(), 16'h0000);
    // A later switch change overrides the remote setting; new value differs from 3
    switch_intensity = (switch_intensity == 2'h2) ? 2'h0 : switch_intensity + 2'h1;
    repeat (3) @(posedge core_clk);
    #1;
    check(cfg.intensity, switch_intensity);
    // Idle until test mode lapses with one flash
    exp_q.push_back(2'h0);
    cnt = 0;
    while (test_mode !== 1'b0 && cnt < 25000) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    check(test_mode, 1'b0);
    while (busy !== 1'b0) begin
      @(posedge core_clk);
      #1;
    end
    repeat (10) @(posedge core_clk);
    check(exp_q.size(), 16'h0000);
    wrap_up;
  end
endmodule
